// ===== hdl/fbh_pkg.sv
// Package of constants and types for the dual-bank flash host controller.
package fbh_pkg;

    // Host command codes presented on cmd_op_i.
    localparam logic [1:0] CMD_READ      = 2'h0;
    localparam logic [1:0] CMD_WRITE     = 2'h1;
    localparam logic [1:0] CMD_RESET     = 2'h2;

    // Bus phase timing in nanoseconds and the clock period.
    localparam int CLK_PERIOD_NS  = 100;
    localparam int SETUP_NS       = 100;
    localparam int ACCESS_NS      = 200;
    localparam int WRITE_PULSE_NS = 100;
    localparam int HOLD_NS        = 100;
    localparam int RESET_PULSE_NS = 500;
    localparam int RESET_HIGH_NS  = 200;

    // Least times round up to whole cycles, never below one.
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int SETUP_CYC    = ns_to_cyc(SETUP_NS);
    localparam int ACCESS_CYC   = ns_to_cyc(ACCESS_NS);
    localparam int WPULSE_CYC   = ns_to_cyc(WRITE_PULSE_NS);
    localparam int HOLD_CYC     = ns_to_cyc(HOLD_NS);
    localparam int RPULSE_CYC   = ns_to_cyc(RESET_PULSE_NS);
    localparam int RHIGH_CYC    = ns_to_cyc(RESET_HIGH_NS);

    // Controller states, one-hot.
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_SETUP  = 6'h02,
        ST_ACCESS = 6'h04,
        ST_STROBE = 6'h08,
        ST_HOLD   = 6'h10,
        ST_RESET  = 6'h20
    } fbh_state_t;

endpackage : fbh_pkg

// ===== hdl/fbh_host.sv
// Clocked host controller that sequences the flash control pins.
//
// Operation
// - Read: select and output enable low.
// - Write: enable and select low, OE high.
// - Unlock bypass programs take two writes.
// - High voltage only for accelerated programming.
`timescale 1ns/1ps
module fbh_host
    import fbh_pkg::*;
#(
    parameter int ADDR_W = 21
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              cmd_valid_i,
    output logic                   cmd_ready_o,
    input  wire logic [1:0]        cmd_op_i,
    input  wire logic [ADDR_W-1:0] cmd_addr_i,
    input  wire logic [15:0]       cmd_wdata_i,
    input  wire logic              word_mode_i,
    input  wire logic              accel_req_i,
    output logic                   rsp_valid_o,
    output logic [15:0]            rsp_rdata_o,
    output logic                   flash_sel_n_o,
    output logic                   out_en_n_o,
    output logic                   wr_en_n_o,
    output logic                   reset_n_o,
    output logic                   flash_width_select_o,
    output logic                   protect_accel_pin_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic [15:0]            dq_o,
    output logic [15:0]            dq_oe_o,
    input  wire logic [15:0]       dq_i
);

    // Refuse widths the pins cannot carry and counts the counter cannot hold.
    if (ADDR_W < 2 || ADDR_W > 30 ||
        RPULSE_CYC + RHIGH_CYC > 16 || ACCESS_CYC + 2 > 15) begin : g_bad_cfg
        $error("fbh_host configuration out of range");
    end

    fbh_state_t        state_q;
    logic [3:0]        cnt_q;
    logic [1:0]        op_q;
    logic              byte_q;
    logic [15:0]       wdata_q;
    logic [15:0]       s1_q;
    logic [15:0]       s2_q;
    logic [15:0]       s3_q;
    logic              go;

    // Handshake: a command is taken only when idle.
    assign cmd_ready_o = (state_q == ST_IDLE);
    assign go          = cmd_valid_i && cmd_ready_o;

    // Three-stage capture of the data pins; stable when stages 2 and 3 agree.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= 16'h0000;
            s2_q <= 16'h0000;
            s3_q <= 16'h0000;
        end else begin
            s1_q <= dq_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Pin sequencer; each phase spans a counted number of cycles.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            cnt_q   <= 4'h0;
            op_q    <= CMD_READ;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        op_q <= cmd_op_i;
                        if (cmd_op_i == CMD_RESET) begin
                            // Reset pulse aborts everything in the flash.
                            state_q <= ST_RESET;
                            cnt_q   <= 4'(RPULSE_CYC + RHIGH_CYC - 1);
                        end else begin
                            state_q <= ST_SETUP;
                            cnt_q   <= 4'(SETUP_CYC - 1);
                        end
                    end
                end
                ST_SETUP: begin
                    if (cnt_q == 4'h0) begin
                        state_q <= (op_q == CMD_READ) ? ST_ACCESS
                                                      : ST_STROBE;
                        // Three extra cycles let the pin pipe fill with
                        // data launched after output enable fell.
                        cnt_q   <= (op_q == CMD_READ) ? 4'(ACCESS_CYC + 2)
                                                      : 4'(WPULSE_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                ST_ACCESS, ST_STROBE: begin
                    if (cnt_q == 4'h0) begin
                        state_q <= ST_HOLD;
                        cnt_q   <= 4'(HOLD_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                ST_HOLD, ST_RESET: begin
                    if (cnt_q == 4'h0) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Address and data latched at acceptance; byte lane chosen by width.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_o  <= '0;
            wdata_q <= 16'h0000;
            byte_q  <= 1'b0;
        end else if (go) begin
            addr_o <= cmd_addr_i;
            byte_q <= !word_mode_i;
            if (word_mode_i) begin
                wdata_q <= cmd_wdata_i;
            end else begin
                // Bit 15 carries the byte address while data uses the low byte.
                wdata_q <= {cmd_addr_i[0], 7'h00, cmd_wdata_i[7:0]};
            end
        end
    end

    // Control strobes registered so the pins never glitch.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flash_sel_n_o        <= 1'b1;
            out_en_n_o           <= 1'b1;
            wr_en_n_o            <= 1'b1;
            reset_n_o            <= 1'b0;
            flash_width_select_o <= 1'b1;
            protect_accel_pin_o  <= 1'b0;
        end else begin
            // Deselected between commands so the flash idles in standby.
            flash_sel_n_o <= !(state_q inside {ST_SETUP, ST_ACCESS,
                                               ST_STROBE, ST_HOLD});
            out_en_n_o    <= !(state_q == ST_ACCESS);
            wr_en_n_o     <= !(state_q == ST_STROBE);
            reset_n_o     <= !(state_q == ST_RESET &&
                               cnt_q >= 4'(RHIGH_CYC));
            if (state_q == ST_IDLE) begin
                flash_width_select_o <= word_mode_i;
                // High voltage rides only on an accepted write, so an idle
                // or reading bus never sees it.
                protect_accel_pin_o  <= accel_req_i && go &&
                                        (cmd_op_i == CMD_WRITE);
            end
        end
    end

    // Data pin drive: only during write setup, strobe and hold phases, and byte-address in byte-mode reads.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dq_o    <= 16'h0000;
            dq_oe_o <= 16'h0000;
        end else begin
            dq_o <= wdata_q;
            if (state_q inside {ST_SETUP, ST_STROBE, ST_HOLD} &&
                op_q == CMD_WRITE) begin
                dq_oe_o <= byte_q ? 16'h80FF : 16'hFFFF;
            end else if (byte_q && state_q == ST_ACCESS) begin
                dq_oe_o <= 16'h8000;
            end else begin
                dq_oe_o <= 16'h0000;
            end
        end
    end

    // Read data captured at the end of the access phase.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= 16'h0000;
        end else begin
            rsp_valid_o <= (state_q == ST_ACCESS && cnt_q == 4'h0);
            if (state_q == ST_ACCESS && cnt_q == 4'h0) begin
                rsp_rdata_o <= byte_q ? {8'h00, s3_q[7:0]} : s3_q;
            end
        end
    end

    // Read strobe never overlaps the write strobe.
    no_overlap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !(!out_en_n_o && !wr_en_n_o))
        else $error("output enable and write enable both low");

    // Write strobe only with chip selected.
    wr_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !wr_en_n_o |-> !flash_sel_n_o)
        else $error("write strobe without select");

    // Read strobe only with chip selected.
    rd_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !out_en_n_o |-> !flash_sel_n_o && wr_en_n_o)
        else $error("read strobe without select");

    // Data not driven while the flash may drive the low byte.
    rd_hiz_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !out_en_n_o |-> dq_oe_o[7:0] == 8'h00)
        else $error("host drives data during read");

    // A read answers within a bounded window.
    sequence read_taken_s;
        go && cmd_op_i == CMD_READ;
    endsequence
    rd_answer_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        read_taken_s |-> ##[2:10] rsp_valid_o)
        else $error("read answer missing");

    // Reset pulse lasts the full pulse width.
    rst_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $fell(reset_n_o) |-> !reset_n_o [*5])
        else $error("reset pulse too short");

    // No select or read strobe while reset is low.
    rst_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !reset_n_o |-> flash_sel_n_o && out_en_n_o)
        else $error("strobes during reset");

    // Byte mode drives byte address on bit 15 during reads.
    byte_addr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!out_en_n_o && !flash_width_select_o) |-> dq_oe_o[15])
        else $error("byte address not driven");

    // The accel level never accompanies a read.
    accel_no_rd_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !out_en_n_o |-> !protect_accel_pin_o)
        else $error("accel level during read");

    // Read data is taken only once the last two pipe stages agree.
    rd_settled_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_q == ST_ACCESS && cnt_q == 4'h0) |-> s2_q == s3_q)
        else $error("read data not settled");

endmodule : fbh_host

// ===== sim/fbh_flash_model.sv
// Pin-level behavioural model of the dual-bank flash die.
`timescale 1ns/1ps
module fbh_flash_model (
    input  wire logic        sel_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        rst_n_i,
    input  wire logic        width_i,
    input  wire logic        prot_i,
    input  wire logic [20:0] addr_i,
    input  wire logic [15:0] dq_i,
    output logic      [15:0] dq_o,
    output logic      [15:0] dq_oe_o
);
    logic [15:0] mem [0:63];
    logic [5:0]  idx;
    logic        boot;

    // Top bit picks the bank; small bank offsets 16 up stand for boot.
    assign idx  = {addr_i[20], addr_i[4:0]};
    assign boot = !addr_i[20] && addr_i[4];

    // Known contents at power-up, readable with no command.
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = 16'h3C00 + 16'(i);
        end
    end

    // Drive only while selected, reading and out of reset.
    always_comb begin
        dq_oe_o = 16'h0000;
        dq_o    = mem[idx];
        if (!sel_n_i && !oe_n_i && we_n_i && rst_n_i) begin
            dq_oe_o = width_i ? 16'hFFFF : 16'h00FF;
            if (!width_i && dq_i[15]) begin
                dq_o = {8'h00, mem[idx][15:8]};
            end
        end
    end

    // Data lands on the rising strobe; boot space needs the pin high.
    always @(posedge we_n_i) begin
        if (!sel_n_i && oe_n_i && rst_n_i &&
            (prot_i || !boot)) begin
            if (width_i) begin
                mem[idx] <= dq_i;
            end else if (dq_i[15]) begin
                mem[idx][15:8] <= dq_i[7:0];
            end else begin
                mem[idx][7:0] <= dq_i[7:0];
            end
        end
    end
endmodule : fbh_flash_model

// ===== sim/fbh_host_bench.sv
// Self-checking bench for the flash host controller.
`timescale 1ns/1ps
module fbh_host_bench;
    import fbh_pkg::*;
    logic ref_clk_i, rst_n_i, cmd_valid_i, cmd_ready_o, word_mode_i;
    logic accel_req_i, rsp_valid_o, flash_sel_n_o, out_en_n_o;
    logic wr_en_n_o, reset_n_o, width_o, prot_o;
    logic [1:0]  cmd_op_i;
    logic [20:0] cmd_addr_i, addr_o;
    logic [15:0] cmd_wdata_i, rsp_rdata_o, dq_o, dq_oe_o, dq_i, m_d, m_oe;
    int error_cnt, n_compared, cyc, we_cnt;

    // Wire level: host, else flash, else a changing floating value.
    assign dq_i = (dq_oe_o & dq_o) | (~dq_oe_o & m_oe & m_d)
                | (~dq_oe_o & ~m_oe & ~dq_o);

    fbh_host fbh_host_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
        .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
        .cmd_wdata_i(cmd_wdata_i), .word_mode_i(word_mode_i),
        .accel_req_i(accel_req_i), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .flash_sel_n_o(flash_sel_n_o),
        .out_en_n_o(out_en_n_o), .wr_en_n_o(wr_en_n_o),
        .reset_n_o(reset_n_o), .flash_width_select_o(width_o),
        .protect_accel_pin_o(prot_o), .addr_o(addr_o), .dq_o(dq_o),
        .dq_oe_o(dq_oe_o), .dq_i(dq_i));
    fbh_flash_model fbh_flash_model_i (.sel_n_i(flash_sel_n_o),
        .oe_n_i(out_en_n_o), .we_n_i(wr_en_n_o), .rst_n_i(reset_n_o),
        .width_i(width_o), .prot_i(prot_o), .addr_i(addr_o),
        .dq_i(dq_i), .dq_o(m_d), .dq_oe_o(m_oe));

    task automatic chk(input string what, input logic [15:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    task automatic wrap_up;
        $display("mismatches %0d of %0d compared", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // Present one request and hold it until the accepting edge.
    task automatic start(input logic [1:0] op, input logic [20:0] a,
                         input logic [15:0] d, input logic w);
        int k;
        #10 cmd_op_i = op;
        cmd_addr_i = a;
        cmd_wdata_i = d;
        word_mode_i = w;
        cmd_valid_i = 1'b1;
        k = 0;
        do @(posedge ref_clk_i); while (cmd_ready_o !== 1'b1 && ++k < 40);
        #10 cmd_valid_i = 1'b0;
        chk("busy ready", 16'h0000, {15'h0, cmd_ready_o});
    endtask : start

    task automatic finish_op;
        int k;
        k = 0;
        do @(posedge ref_clk_i); while (cmd_ready_o !== 1'b1 && ++k < 40);
    endtask : finish_op

    task automatic wr(input logic [20:0] a, input logic [15:0] d,
                      input logic w);
        start(CMD_WRITE, a, d, w);
        finish_op();
    endtask : wr

    // Byte mode answers carry data on the low byte only.
    task automatic rd(input logic [20:0] a, input logic w,
                      input logic [15:0] exp);
        int k;
        start(CMD_READ, a, 16'h0000, w);
        k = 0;
        do @(posedge ref_clk_i); while (rsp_valid_o !== 1'b1 && ++k < 20);
        chk("read data", exp, rsp_rdata_o);
        finish_op();
    endtask : rd

    task automatic s_power_up;
        chk("idle pins", 16'h000F, {12'h0, flash_sel_n_o, out_en_n_o,
            wr_en_n_o, reset_n_o});
        chk("idle drive", 16'h0000, dq_oe_o);
        rd(21'h000003, 1'b1, 16'h3C03);
    endtask : s_power_up

    // Two writes in a row must cost exactly two write strobes.
    task automatic s_word_and_bank;
        int n;
        n = we_cnt;
        wr(21'h100005, 16'hBEEF, 1'b1);
        wr(21'h100006, 16'h0A0B, 1'b1);
        chk("write strobes", 16'h0002, 16'(we_cnt - n));
        rd(21'h100005, 1'b1, 16'hBEEF);
        rd(21'h000005, 1'b1, 16'h3C05);
        rd(21'h100006, 1'b1, 16'h0A0B);
    endtask : s_word_and_bank

    task automatic s_byte;
        wr(21'h00000B, 16'h005A, 1'b0);
        wr(21'h00000A, 16'h00A5, 1'b0);
        rd(21'h00000B, 1'b0, 16'h005A);
        rd(21'h00000A, 1'b0, 16'h00A5);
    endtask : s_byte

    task automatic s_protect;
        wr(21'h000012, 16'h1234, 1'b1);
        rd(21'h000012, 1'b1, 16'h3C12);
        #10 accel_req_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        chk("accel idle", 16'h0000, {15'h0, prot_o});
        wr(21'h000012, 16'h1234, 1'b1);
        rd(21'h000012, 1'b1, 16'h1234);
        #10 accel_req_i = 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chk("accel pin", 16'h0000, {15'h0, prot_o});
    endtask : s_protect

    // The pulse length is counted, then reads must work at once.
    task automatic s_flash_reset;
        int n;
        start(CMD_RESET, 21'h000000, 16'h0000, 1'b1);
        n = 0;
        repeat (12) @(posedge ref_clk_i) if (reset_n_o === 1'b0) n++;
        chk("reset cycles", 16'(RPULSE_CYC), 16'(n));
        finish_op();
        rd(21'h100005, 1'b1, 16'hBEEF);
    endtask : s_flash_reset

    // Strobe levels and the accel level are checked at every falling strobe.
    always @(negedge out_en_n_o) begin
        chk("we at oe", 16'h0001, {15'h0, wr_en_n_o});
        chk("accel at oe", 16'h0000, {15'h0, prot_o});
    end
    always @(negedge wr_en_n_o) begin
        chk("oe at we", 16'h0001, {15'h0, out_en_n_o});
        chk("accel at we", {15'h0, accel_req_i}, {15'h0, prot_o});
        we_cnt++;
    end

    // A hang ends the run as a mismatch.
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            wrap_up();
        end
    end

    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        {cmd_valid_i, word_mode_i, accel_req_i, cmd_op_i} = 5'h08;
        {cmd_addr_i, cmd_wdata_i, error_cnt, n_compared, cyc, we_cnt} = '0;
        rst_n_i = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #10 rst_n_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        s_power_up();
        s_word_and_bank();
        s_byte();
        s_protect();
        s_flash_reset();
        wrap_up();
    end
endmodule : fbh_host_bench
